// File: inc/tmr_defines.svh
/*
  Offsets, bit positions, reset values and pin indices for the timer block.
  Assumes an 8-bit special function register space with byte addresses.
*/
`ifndef TMR_DEFINES_SVH
`define TMR_DEFINES_SVH

`define TMR_ADDR_TL0 8'h8a
`define TMR_ADDR_TL1 8'h8b
`define TMR_ADDR_TH0 8'h8c
`define TMR_ADDR_TH1 8'h8d
`define TMR_ADDR_TIMER2_CONTROL 8'hc8
`define TMR_ADDR_RL2 8'hca
`define TMR_ADDR_RH2 8'hcb
`define TMR_ADDR_TL2 8'hcc
`define TMR_ADDR_TH2 8'hcd

`define TMR_TIMER2_CONTROL_RESET 8'h00
`define TMR_DATA_RESET 8'h00
`define TMR_UNMAPPED_READ 8'h00

`define TMR_BIT_TF2 7
`define TMR_BIT_TIMER2_EXTERNAL_FLAG 6
`define TMR_BIT_RCLK 5
`define TMR_BIT_SERIAL_TX_CLOCK_SELECT 4
`define TMR_BIT_TIMER2_EXTERNAL_ENABLE 3
`define TMR_BIT_TR2 2
`define TMR_BIT_TIMER2_FUNCTION_SELECT 1
`define TMR_BIT_TIMER2_CAPTURE_SELECT 0

`define TMR_PIN_T0 0
`define TMR_PIN_T1 1
`define TMR_PIN_T2 2
`define TMR_PIN_TIMER2_TRIGGER_PIN 3
`define TMR_PIN_EXTERNAL_IRQ0_INPUT 4
`define TMR_PIN_INT1 5
`define TMR_NPINS 6

`endif

// File: inc/tmr_pkg.sv
/*
  Types shared by the timer block: basic timer configuration and state.
  Assumes tmr_defines.svh is on the include path.
*/
`include "tmr_defines.svh"

package tmr_pkg;

  typedef enum logic [1:0] {
    TMR_MODE_13BIT,
    TMR_MODE_16BIT,
    TMR_MODE_RELOAD8,
    TMR_MODE_SPLIT
  } tmr_mode_t;

  typedef struct packed {
    logic run;
    logic gate;
    logic counter;
    tmr_mode_t mode;
  } tmr_tcfg_t;

  typedef struct packed {
    logic [`TMR_NPINS-1:0] sync1;
    logic [`TMR_NPINS-1:0] sync2;
    logic [`TMR_NPINS-1:0] prev;
    logic [7:0] tl0;
    logic [7:0] th0;
    logic [7:0] tl1;
    logic [7:0] th1;
    logic tf0;
    logic tf1;
    logic [7:0] timer2_control;
    logic [7:0] tl2;
    logic [7:0] th2;
    logic [7:0] rl2;
    logic [7:0] rh2;
    logic [7:0] rdata;
    logic rx_tick;
    logic tx_tick;
  } tmr_state_t;

endpackage : tmr_pkg

// File: core/tmr_timers.sv
/*
  Basic timers 0/1 (8-bit autoreload and split modes) and timer 2 with its
  control, count and capture/reload registers, plus the serial baud ticks.
  Assumes a core-side register port with a one-cycle write strobe, pins that
  are asynchronous to clk_i, and a core clock of 100 MHz.
*/
// How it works
// - timer autoreload mode: low byte counts; overflow sets flag (not timer 1's while timer 0 is split), reloads from high byte.
// - timer 1 in split mode stops and holds, as if its run bit were cleared.
// - timer 0 split mode: low byte is its own 8-bit counter with timer 0 controls.
// - timer 0 split mode: high byte counts cycles, uses timer 1 run and flag.
// - timer 1 keeps giving baud overflows while timer 0 is split, unless split itself.
// - timer 2 overflow flag set on overflow, never in baud mode, cleared by software.
// - external flag set when a trigger falling edge causes capture or reload.
// - receive clock select picks timer 2 or timer 1 overflow ticks.
// - transmit clock select picks timer 2 or timer 1 overflow ticks.
// - external enable lets trigger edges act, only while timer 2 runs and outside baud mode.
// - timer 2 run bit starts and stops it; cleared means off.
// - function select counts count pin falling edges, else every core clock.
// - capture select chooses capture on trigger, else reload on overflow and trigger.
// - either serial clock select forces autoreload on each overflow.
// - mode decode: autoreload, capture or baud when running.
// - timer 2 has count byte pair and capture/reload byte pair.
// - basic timer advances only with run set and gate clear or irq pin high; split high byte needs only timer 1 run.
// - autoreload copies the capture/reload pair into the count pair.
// - capture copies low and high count bytes into the reload bytes.
// - timer function advances once per core clock, no prescaler.
module tmr_timers (
  input wire logic clk_i,
  input wire logic sys_rst_i,
  input wire logic [7:0] sfr_addr_i,
  input wire logic sfr_wr_i,
  input wire logic [7:0] sfr_wdata_i,
  output logic [7:0] sfr_rdata_o,
  input wire tmr_pkg::tmr_tcfg_t timer0_cfg_i,
  input wire tmr_pkg::tmr_tcfg_t timer1_cfg_i,
  input wire logic timer0_overflow_clear_i,
  input wire logic timer1_overflow_clear_i,
  input wire logic timer0_count_pin_i,
  input wire logic timer1_count_pin_i,
  input wire logic timer2_count_pin_i,
  input wire logic timer2_trigger_pin_i,
  input wire logic external_irq0_input_i,
  input wire logic external_irq1_input_i,
  output logic timer0_overflow_flag_o,
  output logic timer1_overflow_flag_o,
  output logic timer2_overflow_flag_o,
  output logic timer2_external_flag_o,
  output logic serial_rx_tick_o,
  output logic serial_tx_tick_o
);

  // returns {carry, next value} of an 8-bit counter step
  function automatic logic [8:0] step8(input logic [7:0] v, input logic en);
    logic [8:0] r;
    r = {1'b0, v};
    if (en) begin
      r = {1'b0, v} + 9'h001;
    end
    return r;
  endfunction : step8

  tmr_pkg::tmr_state_t s_q;
  tmr_pkg::tmr_state_t s_d;

  logic [`TMR_NPINS-1:0] fall;
  logic wr_tl0, wr_th0, wr_tl1, wr_th1, wr_timer2_control, wr_rl2, wr_rh2, wr_tl2, wr_th2;
  logic t0_split, t1_split, t0_reload, t1_reload;
  logic en0, en1, en_th0;
  logic [8:0] tl0_step, th0_step, tl1_step;
  logic ov0, ov_th0, ov1;
  logic tr2, baud, timer2_capture_select, timer2_external_enable, timer2_function_select;
  logic en2, ov2, ext_ev;
  logic [15:0] timer2_function_select_q, timer2_function_select_inc, reload2;

  always_comb begin
    // prev follows the second stage, so the first stage feeds nothing else
    fall = s_q.prev & ~s_q.sync2;
    wr_tl0 = sfr_wr_i && sfr_addr_i == `TMR_ADDR_TL0;
    wr_th0 = sfr_wr_i && sfr_addr_i == `TMR_ADDR_TH0;
    wr_tl1 = sfr_wr_i && sfr_addr_i == `TMR_ADDR_TL1;
    wr_th1 = sfr_wr_i && sfr_addr_i == `TMR_ADDR_TH1;
    wr_timer2_control = sfr_wr_i && sfr_addr_i == `TMR_ADDR_TIMER2_CONTROL;
    wr_rl2 = sfr_wr_i && sfr_addr_i == `TMR_ADDR_RL2;
    wr_rh2 = sfr_wr_i && sfr_addr_i == `TMR_ADDR_RH2;
    wr_tl2 = sfr_wr_i && sfr_addr_i == `TMR_ADDR_TL2;
    wr_th2 = sfr_wr_i && sfr_addr_i == `TMR_ADDR_TH2;
  end

  // basic timers
  always_comb begin
    t0_split = timer0_cfg_i.mode == tmr_pkg::TMR_MODE_SPLIT;
    t1_split = timer1_cfg_i.mode == tmr_pkg::TMR_MODE_SPLIT;
    t0_reload = timer0_cfg_i.mode == tmr_pkg::TMR_MODE_RELOAD8;
    t1_reload = timer1_cfg_i.mode == tmr_pkg::TMR_MODE_RELOAD8;
    en0 = timer0_cfg_i.run
        && (!timer0_cfg_i.gate || s_q.sync2[`TMR_PIN_EXTERNAL_IRQ0_INPUT])
        && (timer0_cfg_i.counter ? fall[`TMR_PIN_T0] : 1'b1)
        && (t0_reload || t0_split);
    // split high byte is locked to cycle counting under timer 1 run
    en_th0 = t0_split && timer1_cfg_i.run;
    // the 13/16-bit modes are not built here; timer 1 holds in them and in split
    en1 = timer1_cfg_i.run
        && (!timer1_cfg_i.gate || s_q.sync2[`TMR_PIN_INT1])
        && (timer1_cfg_i.counter ? fall[`TMR_PIN_T1] : 1'b1)
        && t1_reload;
    tl0_step = step8(s_q.tl0, en0);
    th0_step = step8(s_q.th0, en_th0);
    tl1_step = step8(s_q.tl1, en1);
    ov0 = tl0_step[8];
    ov_th0 = th0_step[8];
    ov1 = tl1_step[8];
  end

  // timer 2 decode
  always_comb begin
    tr2 = s_q.timer2_control[`TMR_BIT_TR2];
    baud = s_q.timer2_control[`TMR_BIT_RCLK] || s_q.timer2_control[`TMR_BIT_SERIAL_TX_CLOCK_SELECT];
    timer2_capture_select = s_q.timer2_control[`TMR_BIT_TIMER2_CAPTURE_SELECT] && !baud;
    timer2_external_enable = s_q.timer2_control[`TMR_BIT_TIMER2_EXTERNAL_ENABLE];
    timer2_function_select = s_q.timer2_control[`TMR_BIT_TIMER2_FUNCTION_SELECT];
    timer2_function_select_q = {s_q.th2, s_q.tl2};
    reload2 = {s_q.rh2, s_q.rl2};
    en2 = tr2 && (timer2_function_select ? fall[`TMR_PIN_T2] : 1'b1);
    ov2 = en2 && timer2_function_select_q == 16'hffff;
    timer2_function_select_inc = timer2_function_select_q + 16'h0001;
    // trigger edges only act while running and not feeding the serial port
    ext_ev = tr2 && timer2_external_enable && !baud && fall[`TMR_PIN_TIMER2_TRIGGER_PIN];
  end

  always_comb begin
    s_d = s_q;
    s_d.sync1 = {external_irq1_input_i, external_irq0_input_i, timer2_trigger_pin_i,
                 timer2_count_pin_i, timer1_count_pin_i, timer0_count_pin_i};
    s_d.sync2 = s_q.sync1;
    s_d.prev = s_q.sync2;

    // timer 0 low byte: reload from high byte in mode 2, free 8-bit in split
    s_d.tl0 = tl0_step[7:0];
    if (ov0 && t0_reload) begin
      s_d.tl0 = s_q.th0;
    end
    s_d.th0 = th0_step[7:0];
    s_d.tl1 = tl1_step[7:0];
    if (ov1) begin
      s_d.tl1 = s_q.th1;
    end
    if (wr_tl0) begin
      s_d.tl0 = sfr_wdata_i;
    end
    if (wr_th0) begin
      s_d.th0 = sfr_wdata_i;
    end
    if (wr_tl1) begin
      s_d.tl1 = sfr_wdata_i;
    end
    if (wr_th1) begin
      s_d.th1 = sfr_wdata_i;
    end

    // a hardware set in the same cycle as a clear wins
    s_d.tf0 = (s_q.tf0 && !timer0_overflow_clear_i) || ov0;
    // while timer 0 is split its high byte owns timer 1's flag
    s_d.tf1 = (s_q.tf1 && !timer1_overflow_clear_i)
           || (t0_split ? ov_th0 : ov1);

    // timer 2 control: software write first, hardware sets on top
    if (wr_timer2_control) begin
      s_d.timer2_control = sfr_wdata_i;
    end
    if (ov2 && !baud) begin
      s_d.timer2_control[`TMR_BIT_TF2] = 1'b1;
    end
    if (ext_ev) begin
      s_d.timer2_control[`TMR_BIT_TIMER2_EXTERNAL_FLAG] = 1'b1;
    end

    // timer 2 count and capture/reload pairs
    if (en2) begin
      s_d.tl2 = timer2_function_select_inc[7:0];
      s_d.th2 = timer2_function_select_inc[15:8];
    end
    if ((ov2 && !timer2_capture_select) || (ext_ev && !timer2_capture_select)) begin
      s_d.tl2 = s_q.rl2;
      s_d.th2 = s_q.rh2;
    end
    if (ext_ev && timer2_capture_select) begin
      s_d.rl2 = s_q.tl2;
      s_d.rh2 = s_q.th2;
    end
    if (wr_tl2) begin
      s_d.tl2 = sfr_wdata_i;
    end
    if (wr_th2) begin
      s_d.th2 = sfr_wdata_i;
    end
    if (wr_rl2) begin
      s_d.rl2 = sfr_wdata_i;
    end
    if (wr_rh2) begin
      s_d.rh2 = sfr_wdata_i;
    end

    // baud ticks: timer 1 overflow still leaves even when timer 0 is split
    s_d.rx_tick = s_q.timer2_control[`TMR_BIT_RCLK] ? ov2 : ov1;
    s_d.tx_tick = s_q.timer2_control[`TMR_BIT_SERIAL_TX_CLOCK_SELECT] ? ov2 : ov1;

    // read data is registered; one cycle after the address
    unique case (sfr_addr_i)
      `TMR_ADDR_TL0: s_d.rdata = s_q.tl0;
      `TMR_ADDR_TH0: s_d.rdata = s_q.th0;
      `TMR_ADDR_TL1: s_d.rdata = s_q.tl1;
      `TMR_ADDR_TH1: s_d.rdata = s_q.th1;
      `TMR_ADDR_TIMER2_CONTROL: s_d.rdata = s_q.timer2_control;
      `TMR_ADDR_RL2: s_d.rdata = s_q.rl2;
      `TMR_ADDR_RH2: s_d.rdata = s_q.rh2;
      `TMR_ADDR_TL2: s_d.rdata = s_q.tl2;
      `TMR_ADDR_TH2: s_d.rdata = s_q.th2;
      default: s_d.rdata = `TMR_UNMAPPED_READ;
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      s_q <= '0;
      s_q.sync1 <= '1;
      s_q.sync2 <= '1;
      s_q.prev <= '1;
      s_q.timer2_control <= `TMR_TIMER2_CONTROL_RESET;
      s_q.tl2 <= `TMR_DATA_RESET;
      s_q.th2 <= `TMR_DATA_RESET;
      s_q.rl2 <= `TMR_DATA_RESET;
      s_q.rh2 <= `TMR_DATA_RESET;
    end else begin
      s_q <= s_d;
    end
  end

  assign sfr_rdata_o = s_q.rdata;
  assign timer0_overflow_flag_o = s_q.tf0;
  assign timer1_overflow_flag_o = s_q.tf1;
  assign timer2_overflow_flag_o = s_q.timer2_control[`TMR_BIT_TF2];
  assign timer2_external_flag_o = s_q.timer2_control[`TMR_BIT_TIMER2_EXTERNAL_FLAG];
  assign serial_rx_tick_o = s_q.rx_tick;
  assign serial_tx_tick_o = s_q.tx_tick;

  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (sys_rst_i);

  a_t0_reload_byte: assert property (t0_reload && ov0 && !wr_tl0 |=>
      s_q.tl0 == $past(s_q.th0) && s_q.tf0)
    else $error("timer 0 reload from high byte missing");

  a_t1_split_hold: assert property (t1_split && !wr_tl1 && !wr_th1 |=>
      $stable(s_q.tl1) && $stable(s_q.th1))
    else $error("timer 1 moved in split mode");

  a_t0_split_wrap: assert property (t0_split && en0 && s_q.tl0 == 8'hff && !wr_tl0 |=>
      s_q.tl0 == 8'h00 && s_q.tf0)
    else $error("split low byte did not wrap and flag");

  a_th0_owns_tf1: assert property (t0_split && timer1_cfg_i.run && s_q.th0 == 8'hff
      && !wr_th0 |=> s_q.tf1 && s_q.th0 == 8'h00)
    else $error("split high byte overflow lost");

  a_t1_baud_split: assert property (t0_split && ov1 && !s_q.timer2_control[`TMR_BIT_SERIAL_TX_CLOCK_SELECT] |=>
      serial_tx_tick_o)
    else $error("timer 1 tick lost in split mode");

  a_tf2_baud_quiet: assert property (baud && !wr_timer2_control |=>
      !$rose(timer2_overflow_flag_o))
    else $error("overflow flag set in baud mode");

  a_tf2_sticky: assert property (timer2_overflow_flag_o && !wr_timer2_control |=>
      timer2_overflow_flag_o)
    else $error("overflow flag cleared without software");

  a_timer2_external_flag_set: assert property (ext_ev |=> timer2_external_flag_o)
    else $error("external flag not set by trigger edge");

  a_rx_clock_sel: assert property (ov2 && s_q.timer2_control[`TMR_BIT_RCLK] ##1 1'b1 |->
      serial_rx_tick_o)
    else $error("receive tick not from timer 2");

  a_tx_clock_sel: assert property (ov1 && !s_q.timer2_control[`TMR_BIT_SERIAL_TX_CLOCK_SELECT] |=>
      serial_tx_tick_o)
    else $error("transmit tick not from timer 1");

  a_ext_ignored: assert property (!timer2_external_enable && !wr_timer2_control |=>
      !$rose(timer2_external_flag_o))
    else $error("trigger acted with external enable clear");

  a_t2_off_hold: assert property ((!tr2 && !wr_tl2 && !wr_th2) [*2] |->
      $stable(timer2_function_select_q))
    else $error("timer 2 moved while stopped");

  a_t2_off_noflag: assert property (!tr2 && !wr_timer2_control |=>
      !$rose(timer2_overflow_flag_o))
    else $error("overflow flag set while timer 2 off");

  a_t2_cap_wrap: assert property (ov2 && timer2_capture_select && !wr_tl2 && !wr_th2 && !wr_timer2_control |=>
      timer2_function_select_q == 16'h0000 && timer2_overflow_flag_o)
    else $error("capture mode overflow did not wrap and flag");

  a_t2_write_low: assert property (wr_tl2 |=> s_q.tl2 == $past(sfr_wdata_i))
    else $error("count low byte write lost");

  a_t2_pin_step: assert property (tr2 && timer2_function_select && fall[`TMR_PIN_T2] && timer2_function_select_q != 16'hffff
      && !ext_ev && !wr_tl2 && !wr_th2 |=> timer2_function_select_q == $past(timer2_function_select_q) + 16'h0001)
    else $error("count pin edge did not step timer 2");

  a_rx_from_t1: assert property (ov1 && !s_q.timer2_control[`TMR_BIT_RCLK] |=>
      serial_rx_tick_o)
    else $error("receive tick not from timer 1");

  a_t1_gate_block: assert property (timer1_cfg_i.gate && !s_q.sync2[`TMR_PIN_INT1]
      && !wr_tl1 |=> $stable(s_q.tl1))
    else $error("gated timer 1 advanced");

  a_th0_untouched: assert property (t0_reload && ov0 && !wr_th0 |=>
      $stable(s_q.th0))
    else $error("reload disturbed the high byte");

  a_t2_counter_hold: assert property (tr2 && timer2_function_select && !fall[`TMR_PIN_T2] && !ext_ev
      && !wr_tl2 && !wr_th2 |=> $stable(timer2_function_select_q))
    else $error("counter function moved without pin edge");

  a_t2_capture: assert property (ext_ev && timer2_capture_select && !wr_rl2 && !wr_rh2 |=>
      reload2 == $past(timer2_function_select_q))
    else $error("capture did not copy count");

  a_t2_reload: assert property (ov2 && !timer2_capture_select && !wr_tl2 && !wr_th2 |=>
      timer2_function_select_q == $past(reload2))
    else $error("overflow did not reload count");

  a_t2_per_cycle: assert property (tr2 && !timer2_function_select && timer2_function_select_q != 16'hffff && !ext_ev
      && !wr_tl2 && !wr_th2 |=> timer2_function_select_q == $past(timer2_function_select_q) + 16'h0001)
    else $error("timer function did not step each cycle");

  a_t0_gate_block: assert property (timer0_cfg_i.gate && !s_q.sync2[`TMR_PIN_EXTERNAL_IRQ0_INPUT]
      && !wr_tl0 |=> $stable(s_q.tl0))
    else $error("gated timer 0 advanced");

  a_edge_pulse: assert property (fall[`TMR_PIN_TIMER2_TRIGGER_PIN] |=> !fall[`TMR_PIN_TIMER2_TRIGGER_PIN])
    else $error("edge pulse longer than one cycle");

endmodule : tmr_timers

// File: dv/tmr_pin_model.sv
/*
  Far-side model: drives the timer 2 count and trigger pins and counts the
  baud ticks as the serial port would see them.
  Assumes a 10 ns core clock and pins idling high.
*/
module tmr_pin_model (
  input wire logic clk_i,
  input wire logic serial_rx_tick_i,
  input wire logic serial_tx_tick_i,
  output logic timer2_count_pin_o,
  output logic timer2_trigger_pin_o
);
  timeunit 1ns;
  timeprecision 1ps;
  int rx_cnt = 0;
  int tx_cnt = 0;
  initial begin
    timer2_count_pin_o = 1'b1;
    timer2_trigger_pin_o = 1'b1;
  end
  always @(posedge clk_i) begin
    if (serial_rx_tick_i === 1'b1) rx_cnt <= rx_cnt + 1;
    if (serial_tx_tick_i === 1'b1) tx_cnt <= tx_cnt + 1;
  end
  // each level is held three cycles so the pin synchroniser cannot miss it
  task automatic fall(input bit trig);
    @(posedge clk_i);
    #1;
    if (trig) timer2_trigger_pin_o = 1'b0;
    else timer2_count_pin_o = 1'b0;
    repeat (3) @(posedge clk_i);
    #1;
    timer2_trigger_pin_o = 1'b1;
    timer2_count_pin_o = 1'b1;
    repeat (3) @(posedge clk_i);
  endtask : fall
endmodule : tmr_pin_model

// File: dv/tb_tmr_timers.sv
/*
  Self-checking bench for the timer block: register tasks, pin events via
  the far-side model, flag and baud tick checks.
  Assumes the package is compiled first.
*/
module tb_tmr_timers;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_i = 1'b0;
  logic sys_rst_i = 1'b1;
  logic [7:0] addr = 8'h00;
  logic wr = 1'b0;
  logic [7:0] wdata = 8'h00;
  logic [7:0] rdata;
  tmr_pkg::tmr_tcfg_t cfg0 = '0;
  tmr_pkg::tmr_tcfg_t cfg1 = '0;
  logic clr0 = 1'b0;
  logic clr1 = 1'b0;
  logic irq0 = 1'b0;
  logic irq1 = 1'b1;
  logic tf0, tf1, tf2, timer2_external_flag, rxt, txt, cpin, tpin;
  logic [7:0] v;
  logic [7:0] ra [6] = '{8'hc8, 8'hca, 8'hcb, 8'hcc, 8'hcd, 8'h00};
  int error_cnt = 0;
  int samples_checked = 0;
  int n_rx, n_tx;

  tmr_timers DUT (
    .clk_i(clk_i), .sys_rst_i(sys_rst_i), .sfr_addr_i(addr), .sfr_wr_i(wr),
    .sfr_wdata_i(wdata), .sfr_rdata_o(rdata), .timer0_cfg_i(cfg0), .timer1_cfg_i(cfg1),
    .timer0_overflow_clear_i(clr0), .timer1_overflow_clear_i(clr1),
    .timer0_count_pin_i(1'b1), .timer1_count_pin_i(1'b1), .timer2_count_pin_i(cpin),
    .timer2_trigger_pin_i(tpin), .external_irq0_input_i(irq0),
    .external_irq1_input_i(irq1), .timer0_overflow_flag_o(tf0),
    .timer1_overflow_flag_o(tf1), .timer2_overflow_flag_o(tf2),
    .timer2_external_flag_o(timer2_external_flag), .serial_rx_tick_o(rxt), .serial_tx_tick_o(txt)
  );
  tmr_pin_model PM (
    .clk_i(clk_i), .serial_rx_tick_i(rxt), .serial_tx_tick_i(txt),
    .timer2_count_pin_o(cpin), .timer2_trigger_pin_o(tpin)
  );

  initial forever #5 clk_i = ~clk_i;

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    samples_checked++;
    if (got !== exp) begin
      error_cnt++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic chk1(input logic got, input logic exp);
    chk({7'h00, got}, {7'h00, exp});
  endtask : chk1
  task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_i);
    #1;
    addr = a;
    wdata = d;
    wr = 1'b1;
    @(posedge clk_i);
    #1;
    wr = 1'b0;
  endtask : wr_reg
  task automatic rd_reg(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk_i);
    #1;
    addr = a;
    @(posedge clk_i);
    #1;
    d = rdata;
  endtask : rd_reg
  // one trigger edge under a given control value, then the external flag
  task automatic trig(input logic [7:0] ctl, input logic expf);
    wr_reg(8'hc8, ctl);
    PM.fall(1'b1);
    repeat (4) @(posedge clk_i);
    #1;
    chk1(timer2_external_flag, expf);
  endtask : trig
  task automatic finish_test();
    if (error_cnt == 0 && samples_checked > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : finish_test

  // the full sequence needs about 700 cycles
  initial begin
    repeat (20000) @(posedge clk_i);
    error_cnt++;
    finish_test();
  end

  initial begin
    repeat (10) @(posedge clk_i);
    #1;
    sys_rst_i = 1'b0;
    for (int i = 0; i < 6; i++) begin
      rd_reg(ra[i], v);
      chk(v, 8'h00);
    end
    wr_reg(8'hca, 8'h00);
    wr_reg(8'hcb, 8'h12);
    wr_reg(8'hcd, 8'hff);
    wr_reg(8'hcc, 8'hf0);
    wr_reg(8'hc8, 8'h04);
    repeat (30) @(posedge clk_i);
    #1;
    chk1(tf2, 1'b1);
    wr_reg(8'hc8, 8'h00);
    chk1(tf2, 1'b0);
    rd_reg(8'hcd, v);
    chk(v, 8'h12);
    // period of 16 cycles, so any 160-cycle window holds exactly ten ticks
    wr_reg(8'hca, 8'hf0);
    wr_reg(8'hcb, 8'hff);
    for (int i = 0; i < 2; i++) begin
      wr_reg(8'hcd, 8'hff);
      wr_reg(8'hcc, 8'hf0);
      wr_reg(8'hc8, i ? 8'h1c : 8'h2c);
      repeat (20) @(posedge clk_i);
      #1;
      n_rx = PM.rx_cnt;
      n_tx = PM.tx_cnt;
      PM.fall(1'b1);
      repeat (153) @(posedge clk_i);
      #1;
      chk(8'(PM.rx_cnt - n_rx), i ? 8'h00 : 8'h0a);
      chk(8'(PM.tx_cnt - n_tx), i ? 8'h0a : 8'h00);
      chk1(tf2, 1'b0);
      chk1(timer2_external_flag, 1'b0);
    end
    wr_reg(8'hc8, 8'h00);
    wr_reg(8'hcd, 8'h00);
    wr_reg(8'hcc, 8'h00);
    wr_reg(8'hca, 8'haa);
    wr_reg(8'hcb, 8'haa);
    trig(8'h05, 1'b0);
    trig(8'h0d, 1'b1);
    wr_reg(8'hc8, 8'h00);
    rd_reg(8'hcb, v);
    chk(v, 8'h00);
    rd_reg(8'hca, v);
    chk1(v < 8'h40, 1'b1);
    wr_reg(8'hca, 8'h00);
    wr_reg(8'hcb, 8'h55);
    trig(8'h0c, 1'b1);
    wr_reg(8'hc8, 8'h00);
    rd_reg(8'hcd, v);
    chk(v, 8'h55);
    wr_reg(8'hcd, 8'h00);
    wr_reg(8'hcc, 8'h00);
    wr_reg(8'hc8, 8'h06);
    repeat (5) PM.fall(1'b0);
    repeat (4) @(posedge clk_i);
    wr_reg(8'hc8, 8'h00);
    rd_reg(8'hcc, v);
    chk(v, 8'h05);
    repeat (10) @(posedge clk_i);
    rd_reg(8'hcc, v);
    chk(v, 8'h05);
    wr_reg(8'h8a, 8'hf0);
    wr_reg(8'h8c, 8'h80);
    cfg0 = '{run: 1'b1, gate: 1'b1, counter: 1'b0, mode: tmr_pkg::TMR_MODE_RELOAD8};
    repeat (30) @(posedge clk_i);
    #1;
    chk1(tf0, 1'b0);
    irq0 = 1'b1;
    repeat (40) @(posedge clk_i);
    #1;
    chk1(tf0, 1'b1);
    cfg0.run = 1'b0;
    rd_reg(8'h8c, v);
    chk(v, 8'h80);
    rd_reg(8'h8a, v);
    chk1(v[7], 1'b1);
    clr0 = 1'b1;
    @(posedge clk_i);
    #1;
    clr0 = 1'b0;
    chk1(tf0, 1'b0);
    cfg0.mode = tmr_pkg::TMR_MODE_SPLIT;
    cfg1 = '{run: 1'b1, gate: 1'b0, counter: 1'b0, mode: tmr_pkg::TMR_MODE_SPLIT};
    wr_reg(8'h8b, 8'h33);
    wr_reg(8'h8c, 8'hf0);
    repeat (30) @(posedge clk_i);
    #1;
    chk1(tf1, 1'b1);
    rd_reg(8'h8b, v);
    chk(v, 8'h33);
    cfg1.run = 1'b0;
    clr1 = 1'b1;
    @(posedge clk_i);
    #1;
    clr1 = 1'b0;
    chk1(tf1, 1'b0);
    finish_test();
  end
endmodule : tb_tmr_timers
